// [design/dctc_top.sv]
// Purpose: Control logic for a short and a long down-counter with output combining and
//          an input edge detector with glitch filter.
// Assumes: Single clock; the demodulator pins are asynchronous and are synchronised here.
// Notes:   Both timers count on a shared prescaled enable pulse.
`timescale 1ns/100ps
// How it works
// - Writing enable one starts the short timer.
// - Modulo reloads at terminal count, single stops.
// - Timeout flag set at terminal count, write-one clears.
// - Partial first prescaled period is tolerated.
// - Short output takes initial level on start.
// - Long output takes initial level on start, except in the force low/high submodes.
// - Mode bit zero transmit, one demodulation.
// - Transmit select routes combined output to pin.
// - Demodulation select picks pin A or B.
// - Pin B edges also pulse the capture line.
// - Transmit logic field combines both outputs.
// - Demodulation field selects detected edges.
// - Submode normal, ping-pong, force long low/high.
// - Rising edge sets flag, write one clears.
// - Falling edge sets flag, write one clears.
module dctc_top #(
   parameter int SHORT_W = 8,
   parameter int LONG_W  = 16
) (
   input  wire logic                CORE_CLK,
   input  wire logic                ARST_N,
   input  wire dctc_pkg::dctc_bus_t BUS_REQ,
   output logic [dctc_pkg::DW-1:0]  RD_DATA,
   input  wire logic                DEMOD_PIN_A,
   input  wire logic                DEMOD_PIN_B,
   input  wire logic                PORT_OUT_A,
   input  wire logic                PORT_OUT_B,
   output logic                     TIMER_OUT_PIN_A,
   output logic                     COMBINED_OUT_PIN,
   output logic                     CAPTURE_INTERRUPT_LINE,
   output logic                     IRQ
);
   import dctc_pkg::*;

   logic [2:0]         pre_r;
   logic               short_en_r, long_en_r, single_r, long_single_r, tout_r, long_tout_r;
   logic [1:0]         clksel_r;
   logic               imask_r, osel_r, mode_r, csel_r, init_s_r, init_l_r;
   logic [1:0]         logic_r, sub_r;
   logic               rise_r, fall_r;
   logic [SHORT_W-1:0] short_reload_r, short_cnt_r;
   logic [LONG_W-1:0]  long_reload_r, long_cnt_r;
   logic               short_out_r, long_out_r;
   logic [1:0]         sync_a_r, sync_b_r;
   logic               filt_r, filt_d_r;
   logic [3:0]         gcnt_r;
   logic [IRQ_N-1:0]   stat_r;
   logic [IRQ_N-1:1]   mask_r;

   // Prescaler mask for selected divide of one, two, four or eight.
   function automatic logic [2:0] div_mask(input logic [1:0] sel);
      case (sel)
         2'h0:    div_mask = 3'h0;
         2'h1:    div_mask = 3'h1;
         2'h2:    div_mask = 3'h3;
         default: div_mask = 3'h7;
      endcase
   endfunction

   function automatic logic hit(input logic [AW-1:0] ofs);
      hit = BUS_REQ.wr && (BUS_REQ.addr == ofs);
   endfunction

   logic wr_sc, wr_cc, wr_lc, tick, pingpong, demod;
   logic short_start, long_start, short_tc, long_tc, pp_to_long, pp_to_short;
   logic din, rise_hit, fall_hit, edge_hit, combined;
   logic [3:0] gthr;
   logic [IRQ_N-1:0] stat_set, eff_mask;

   assign wr_sc    = hit(OFS_SHORT_CTL);
   assign wr_cc    = hit(OFS_COMMON_CTL);
   assign wr_lc    = hit(OFS_LONG_CTL);
   assign demod    = mode_r;
   assign pingpong = !demod && (sub_r == SUB_PINGPONG);
   // The prescaler free-runs, so the first tick after enabling may come early.
   assign tick     = (pre_r & div_mask(clksel_r)) == 3'h0;
   assign short_tc = short_en_r && tick && (short_cnt_r == '0);
   assign long_tc  = long_en_r && tick && (long_cnt_r == '0);
   assign pp_to_long  = pingpong && short_tc;
   assign pp_to_short = pingpong && long_tc;
   assign short_start = (wr_sc && BUS_REQ.wdata[B_EN]) || pp_to_short;
   assign long_start  = (wr_lc && BUS_REQ.wdata[B_EN]) || pp_to_long;

   always_ff @(posedge CORE_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         pre_r <= 3'h0;
      end else begin
         pre_r <= pre_r + 3'h1;
      end
   end

   // Control register fields.
   always_ff @(posedge CORE_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         single_r <= 1'b0; long_single_r <= 1'b0; clksel_r <= 2'h0;
         imask_r <= 1'b0; osel_r <= 1'b0; mode_r <= 1'b0; csel_r <= 1'b0;
         logic_r <= 2'h0; sub_r <= 2'h0; init_s_r <= 1'b0; init_l_r <= 1'b0;
         short_reload_r <= '0; long_reload_r <= '0; mask_r <= '0;
      end else begin
         if (wr_sc) begin
            single_r <= BUS_REQ.wdata[B_SINGLE];
            clksel_r <= BUS_REQ.wdata[B_CLK_LO +: 2];
            imask_r  <= BUS_REQ.wdata[B_IMASK];
            osel_r   <= BUS_REQ.wdata[B_OSEL];
         end
         if (wr_lc) begin
            long_single_r <= BUS_REQ.wdata[B_SINGLE];
         end
         if (wr_cc) begin
            mode_r  <= BUS_REQ.wdata[B_MODE];
            csel_r  <= BUS_REQ.wdata[B_CSEL];
            logic_r <= BUS_REQ.wdata[B_LOG_LO +: 2];
            sub_r   <= BUS_REQ.wdata[B_SUB_LO +: 2];
            // In demodulation these positions are flags, so the initial levels keep.
            if (!demod) begin
               init_s_r <= BUS_REQ.wdata[B_INIT_S];
               init_l_r <= BUS_REQ.wdata[B_INIT_L];
            end
         end
         if (hit(OFS_SHORT_RELOAD)) short_reload_r <= BUS_REQ.wdata[SHORT_W-1:0];
         if (hit(OFS_LONG_HI)) long_reload_r[LONG_W-1:DW] <= BUS_REQ.wdata[LONG_W-DW-1:0];
         if (hit(OFS_LONG_LO)) long_reload_r[DW-1:0] <= BUS_REQ.wdata;
         if (hit(OFS_IRQ_MASK)) begin
            mask_r  <= BUS_REQ.wdata[IRQ_N-1:1];
            imask_r <= BUS_REQ.wdata[IRQ_SHORT];
         end
      end
   end

   // Short timer enable, count and output.
   always_ff @(posedge CORE_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         short_en_r <= 1'b0; short_cnt_r <= '0; short_out_r <= 1'b1;
      end else begin
         if (short_start) short_en_r <= 1'b1;
         else if (wr_sc) short_en_r <= 1'b0;
         else if (short_tc && (single_r || pingpong)) short_en_r <= 1'b0;
         if (short_start || short_tc) short_cnt_r <= short_reload_r;
         else if (short_en_r && tick) short_cnt_r <= short_cnt_r - SHORT_W'(1);
         if (short_start) short_out_r <= init_s_r;
         else if (short_tc) short_out_r <= !short_out_r;
         else if (!short_en_r) short_out_r <= !init_s_r;
      end
   end

   // Long timer enable, count and output.
   always_ff @(posedge CORE_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         long_en_r <= 1'b0; long_cnt_r <= '0; long_out_r <= 1'b1;
      end else begin
         if (long_start) long_en_r <= 1'b1;
         else if (wr_lc) long_en_r <= 1'b0;
         else if (long_tc && (long_single_r || pingpong)) long_en_r <= 1'b0;
         if (long_start || long_tc) long_cnt_r <= long_reload_r;
         else if (long_en_r && tick) long_cnt_r <= long_cnt_r - LONG_W'(1);
         if (!demod && sub_r == SUB_FORCE0) long_out_r <= 1'b0;
         else if (!demod && sub_r == SUB_FORCE1) long_out_r <= 1'b1;
         else if (long_start) long_out_r <= init_l_r;
         else if (long_tc) long_out_r <= !long_out_r;
         else if (!long_en_r) long_out_r <= !init_l_r;
      end
   end

   // Timeout flags: a terminal count in the clearing cycle wins.
   always_ff @(posedge CORE_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         tout_r <= 1'b0; long_tout_r <= 1'b0;
      end else begin
         if (short_tc) tout_r <= 1'b1;
         else if (wr_sc && BUS_REQ.wdata[B_TOUT]) tout_r <= 1'b0;
         if (long_tc) long_tout_r <= 1'b1;
         else if (wr_lc && BUS_REQ.wdata[B_TOUT]) long_tout_r <= 1'b0;
      end
   end

   // Input path: two-stage synchronisers, then the glitch filter.
   assign din  = csel_r ? sync_b_r[1] : sync_a_r[1];
   assign gthr = (sub_r == GLITCH_8) ? GLITCH_8_CYC : GLITCH_4_CYC;

   always_ff @(posedge CORE_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         sync_a_r <= 2'h0; sync_b_r <= 2'h0;
         filt_r <= 1'b0; filt_d_r <= 1'b0; gcnt_r <= 4'h0;
      end else begin
         sync_a_r <= {sync_a_r[0], DEMOD_PIN_A};
         sync_b_r <= {sync_b_r[0], DEMOD_PIN_B};
         filt_d_r <= filt_r;
         // Reserved filter code behaves as no filter.
         if (din == filt_r) begin
            gcnt_r <= 4'h0;
         end else if (sub_r == GLITCH_NONE || sub_r == SUB_FORCE1) begin
            filt_r <= din;
         end else if (gcnt_r == gthr - 4'h1) begin
            filt_r <= din;
            gcnt_r <= 4'h0;
         end else begin
            gcnt_r <= gcnt_r + 4'h1;
         end
      end
   end

   assign rise_hit = demod && filt_r && !filt_d_r && (logic_r != EDGE_FALL);
   assign fall_hit = demod && !filt_r && filt_d_r && (logic_r != EDGE_RISE);
   assign edge_hit = rise_hit || fall_hit;

   always_ff @(posedge CORE_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         rise_r <= 1'b0; fall_r <= 1'b0;
      end else begin
         if (rise_hit) rise_r <= 1'b1;
         else if (wr_cc && demod && BUS_REQ.wdata[B_INIT_S]) rise_r <= 1'b0;
         if (fall_hit) fall_r <= 1'b1;
         else if (wr_cc && demod && BUS_REQ.wdata[B_INIT_L]) fall_r <= 1'b0;
      end
   end

   // Interrupt status, write one to clear; events win over the clear.
   assign stat_set = {fall_hit, rise_hit, long_tc, short_tc};
   assign eff_mask = {mask_r, imask_r};

   always_ff @(posedge CORE_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         stat_r <= '0;
      end else begin
         for (int i = 0; i < IRQ_N; i++) begin
            if (stat_set[i]) stat_r[i] <= 1'b1;
            else if (hit(OFS_IRQ_STAT) && BUS_REQ.wdata[i]) stat_r[i] <= 1'b0;
         end
      end
   end

   always_comb begin
      case (logic_r)
         LOG_AND: combined = short_out_r & long_out_r;
         LOG_OR:  combined = short_out_r | long_out_r;
         LOG_NOR: combined = !(short_out_r | long_out_r);
         default: combined = !(short_out_r & long_out_r);
      endcase
   end

   always_ff @(posedge CORE_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         TIMER_OUT_PIN_A <= 1'b0; COMBINED_OUT_PIN <= 1'b0;
         CAPTURE_INTERRUPT_LINE <= 1'b0; IRQ <= 1'b0;
      end else begin
         TIMER_OUT_PIN_A  <= osel_r ? short_out_r : PORT_OUT_A;
         COMBINED_OUT_PIN <= (!demod && csel_r) ? combined : PORT_OUT_B;
         CAPTURE_INTERRUPT_LINE <= edge_hit && csel_r;
         IRQ <= |(stat_r & eff_mask);
      end
   end

   // Read data stand in the cycle after the read strobe only.
   always_ff @(posedge CORE_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         RD_DATA <= '0;
      end else if (!BUS_REQ.rd) begin
         RD_DATA <= '0;
      end else begin
         case (BUS_REQ.addr)
            OFS_SHORT_CTL: RD_DATA <= {short_en_r, single_r, tout_r, clksel_r,
                                       1'b0, imask_r, osel_r};
            OFS_COMMON_CTL: RD_DATA <= {mode_r, csel_r, logic_r, sub_r,
                                        demod ? rise_r : init_s_r,
                                        demod ? fall_r : init_l_r};
            OFS_SHORT_RELOAD: RD_DATA <= DW'(short_reload_r);
            OFS_LONG_HI:   RD_DATA <= long_reload_r[LONG_W-1:DW];
            OFS_LONG_LO:   RD_DATA <= long_reload_r[DW-1:0];
            OFS_LONG_CTL:  RD_DATA <= {long_en_r, long_single_r, long_tout_r, 5'h00};
            OFS_IRQ_STAT:  RD_DATA <= {4'h0, stat_r};
            default:       RD_DATA <= {4'h0, eff_mask};
         endcase
      end
   end

   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (!ARST_N);

   a_start_loads: assert property (short_start |=> short_en_r &&
      short_cnt_r == $past(short_reload_r)) else $error("short start did not load");
   a_single_stops: assert property (short_tc && single_r && !pingpong && !short_start
      |=> !short_en_r) else $error("single pass did not stop");
   a_modulo_runs: assert property (short_tc && !single_r && !pingpong && !wr_sc
      |=> short_en_r && short_cnt_r == $past(short_reload_r)) else $error("modulo did not reload");
   a_tout_sets: assert property (short_tc |=> tout_r ##1 tout_r || $past(wr_sc))
      else $error("timeout flag not held");
   a_init_short: assert property (short_start |=> short_out_r == $past(init_s_r))
      else $error("short output not at initial level");
   a_init_long: assert property (long_start && !demod && !sub_r[1]
      |=> long_out_r == $past(init_l_r)) else $error("long output not at initial level");
   a_force_low: assert property (!demod && sub_r == SUB_FORCE0 |=> !long_out_r)
      else $error("long output not forced low");
   a_rise_flag: assert property (rise_hit |=> rise_r [*2] or ##1 $past(wr_cc))
      else $error("rise flag lost");
   a_fall_flag: assert property (fall_hit |=> fall_r) else $error("fall flag lost");
   a_capture_b: assert property (edge_hit && csel_r |=> CAPTURE_INTERRUPT_LINE)
      else $error("capture line not pulsed");
   a_irq_mask: assert property (!imask_r && !(|(stat_r[IRQ_N-1:1] & mask_r)) |=> !IRQ)
      else $error("masked timeout raised interrupt");

   c_pingpong: cover property (pp_to_long ##[1:1000] pp_to_short);
   c_modulo: cover property (short_tc && !single_r ##[1:300] short_tc);
   c_rise: cover property (rise_hit && csel_r);
   c_glitch: cover property (demod && sub_r == GLITCH_8 && filt_r != filt_d_r);
endmodule

// [design/dctc_pkg.sv]
// Purpose: Shared constants and carrier types of the dual counter/timer control block.
// Assumes: Byte-wide register port with a three-bit register index.
// Notes:   Field positions are bit indices inside each 8-bit register.
package dctc_pkg;
   localparam int AW = 3;
   localparam int DW = 8;

   typedef struct packed {
      logic [AW-1:0] addr;
      logic [DW-1:0] wdata;
      logic          wr;
      logic          rd;
   } dctc_bus_t;

   // Register indices.
   localparam logic [AW-1:0] OFS_SHORT_CTL    = 3'h0;
   localparam logic [AW-1:0] OFS_COMMON_CTL   = 3'h1;
   localparam logic [AW-1:0] OFS_SHORT_RELOAD = 3'h2;
   localparam logic [AW-1:0] OFS_LONG_HI      = 3'h3;
   localparam logic [AW-1:0] OFS_LONG_LO      = 3'h4;
   localparam logic [AW-1:0] OFS_LONG_CTL     = 3'h5;
   localparam logic [AW-1:0] OFS_IRQ_STAT     = 3'h6;
   localparam logic [AW-1:0] OFS_IRQ_MASK     = 3'h7;

   // Timer control fields (short and long control share the upper layout).
   localparam int B_EN     = 7;
   localparam int B_SINGLE = 6;
   localparam int B_TOUT   = 5;
   localparam int B_CLK_LO = 3;
   localparam int B_IMASK  = 1;
   localparam int B_OSEL   = 0;

   // Common control fields.
   localparam int B_MODE   = 7;
   localparam int B_CSEL   = 6;
   localparam int B_LOG_LO = 4;
   localparam int B_SUB_LO = 2;
   localparam int B_INIT_S = 1;
   localparam int B_INIT_L = 0;

   // Interrupt status bits.
   localparam int IRQ_N     = 4;
   localparam int IRQ_SHORT = 0;
   localparam int IRQ_LONG  = 1;
   localparam int IRQ_RISE  = 2;
   localparam int IRQ_FALL  = 3;

   localparam logic [1:0] SUB_NORMAL   = 2'h0;
   localparam logic [1:0] SUB_PINGPONG = 2'h1;
   localparam logic [1:0] SUB_FORCE0   = 2'h2;
   localparam logic [1:0] SUB_FORCE1   = 2'h3;
   localparam logic [1:0] GLITCH_NONE  = 2'h0;
   localparam logic [1:0] GLITCH_4     = 2'h1;
   localparam logic [1:0] GLITCH_8     = 2'h2;
   localparam logic [3:0] GLITCH_4_CYC = 4'h4;
   localparam logic [3:0] GLITCH_8_CYC = 4'h8;
   localparam logic [1:0] LOG_AND      = 2'h0;
   localparam logic [1:0] LOG_OR       = 2'h1;
   localparam logic [1:0] LOG_NOR      = 2'h2;
   localparam logic [1:0] EDGE_RISE    = 2'h0;
   localparam logic [1:0] EDGE_FALL    = 2'h1;
endpackage

// [test/testbench.sv]
// Purpose: Self-checking bench for the dual counter/timer control block.
// Assumes: Prescale code 0 ticks the timers on every clock.
// Notes:   Port values toggle randomly, so pin routing is checked against live data.
`timescale 1ns/100ps
module testbench;
   import dctc_pkg::*;
   logic            CORE_CLK    = 1'b0;
   logic            ARST_N      = 1'b0;
   dctc_bus_t       BUS_REQ     = '0;
   logic [DW-1:0]   RD_DATA;
   logic            DEMOD_PIN_A = 1'b0;
   logic            DEMOD_PIN_B = 1'b0;
   logic            PORT_OUT_A  = 1'b0;
   logic            PORT_OUT_B  = 1'b0;
   logic            TIMER_OUT_PIN_A;
   logic            COMBINED_OUT_PIN;
   logic            CAPTURE_INTERRUPT_LINE;
   logic            IRQ;
   logic            pa_q        = 1'b0;
   logic            pb_q        = 1'b0;
   int              seed        = 31258;
   int              caps        = 0;
   int              cyc         = 0;
   int              mismatches  = 0;
   int              checks      = 0;

   dctc_top dctc_top_i (
      .CORE_CLK               (CORE_CLK),
      .ARST_N                 (ARST_N),
      .BUS_REQ                (BUS_REQ),
      .RD_DATA                (RD_DATA),
      .DEMOD_PIN_A            (DEMOD_PIN_A),
      .DEMOD_PIN_B            (DEMOD_PIN_B),
      .PORT_OUT_A             (PORT_OUT_A),
      .PORT_OUT_B             (PORT_OUT_B),
      .TIMER_OUT_PIN_A        (TIMER_OUT_PIN_A),
      .COMBINED_OUT_PIN       (COMBINED_OUT_PIN),
      .CAPTURE_INTERRUPT_LINE (CAPTURE_INTERRUPT_LINE),
      .IRQ                    (IRQ)
   );

   always #50 CORE_CLK = ~CORE_CLK;

   // The pins register the port values, so the delayed copies are what they should show.
   always @(posedge CORE_CLK) begin
      {PORT_OUT_A, PORT_OUT_B} <= 2'($random(seed));
      pa_q <= PORT_OUT_A;
      pb_q <= PORT_OUT_B;
      cyc <= cyc + 1;
      if (CAPTURE_INTERRUPT_LINE === 1'b1)
         caps <= caps + 1;
      if (cyc > 30000) begin
         mismatches++;
         summarize();
      end
   end

   task automatic summarize();
      if (mismatches == 0 && checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
      checks++;
      if (g !== e) begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic wr(logic [AW-1:0] a, logic [7:0] d);
      @(posedge CORE_CLK);
      BUS_REQ <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge CORE_CLK);
      BUS_REQ.wr <= 1'b0;
   endtask

   task automatic rdchk(string nm, logic [AW-1:0] a, logic [7:0] e);
      @(posedge CORE_CLK);
      BUS_REQ <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge CORE_CLK);
      BUS_REQ.rd <= 1'b0;
      @(negedge CORE_CLK);
      chk(nm, e, RD_DATA);
   endtask

   task automatic cycles(int n);
      repeat (n) @(negedge CORE_CLK);
   endtask

   task automatic period(output int n);
      logic v;
      @(negedge CORE_CLK);
      v = TIMER_OUT_PIN_A;
      n = 1;
      while (TIMER_OUT_PIN_A === v && n < 200) begin
         @(negedge CORE_CLK);
         n++;
      end
   endtask

   task automatic follow(string nm, bit pin_b);
      repeat (4) begin
         @(negedge CORE_CLK);
         if (pin_b)
            chk(nm, {7'h0, pb_q}, {7'h0, COMBINED_OUT_PIN});
         else
            chk(nm, {7'h0, pa_q}, {7'h0, TIMER_OUT_PIN_A});
      end
   endtask

   function automatic logic comb(int lg, logic s, logic l);
      case (lg)
         0: return s & l;
         1: return s | l;
         2: return ~(s | l);
         default: return ~(s & l);
      endcase
   endfunction

   initial begin
      int n;
      int p;
      int rl;
      int v;
      int lg;
      int f;
      int sel;
      int e;
      int g;
      int thr;
      int c0;
      logic [7:0] cfg;
      logic [7:0] fl;
      repeat (5) @(posedge CORE_CLK);
      ARST_N <= 1'b1;
      rdchk("short_ctl", OFS_SHORT_CTL, 8'h00);
      rdchk("common_ctl", OFS_COMMON_CTL, 8'h00);
      wr(OFS_SHORT_CTL, 8'h20);
      follow("pin_a_port", 1'b0);
      wr(OFS_SHORT_RELOAD, 8'h03);
      wr(OFS_SHORT_CTL, 8'hc3);
      cycles(20);
      rdchk("short_ctl", OFS_SHORT_CTL, 8'h63);
      rdchk("irq_stat", OFS_IRQ_STAT, 8'h01);
      rdchk("irq_mask", OFS_IRQ_MASK, 8'h01);
      chk("irq", 8'h01, {7'h0, IRQ});
      chk("pin_a", 8'h01, {7'h0, TIMER_OUT_PIN_A});
      wr(OFS_SHORT_CTL, 8'h43);
      rdchk("short_ctl", OFS_SHORT_CTL, 8'h63);
      wr(OFS_SHORT_CTL, 8'h63);
      wr(OFS_IRQ_STAT, 8'h01);
      cycles(2);
      rdchk("short_ctl", OFS_SHORT_CTL, 8'h43);
      chk("irq", 8'h00, {7'h0, IRQ});
      // The first interval after enable may be partial, so only the last of three measurements is checked.
      for (p = 0; p < 4; p++) begin
         rl = 1 + ($unsigned($random(seed)) % 6);
         wr(OFS_SHORT_RELOAD, 8'(rl));
         wr(OFS_SHORT_CTL, 8'(8'h81 | (p << 3)));
         period(n);
         period(n);
         period(n);
         chk("period", 8'((rl + 1) << p), 8'(n));
         chk("irq_masked", 8'h00, {7'h0, IRQ});
         wr(OFS_SHORT_CTL, 8'h01);
      end
      wr(OFS_SHORT_RELOAD, 8'hff);
      wr(OFS_LONG_HI, 8'hff);
      wr(OFS_LONG_LO, 8'hff);
      for (v = 0; v < 2; v++) begin
         wr(OFS_COMMON_CTL, 8'(8'h40 | (v << 1) | v));
         cycles(3);
         chk("short_idle", 8'(1 - v), {7'h0, TIMER_OUT_PIN_A});
         chk("long_idle", 8'(1 - v), {7'h0, COMBINED_OUT_PIN});
         wr(OFS_SHORT_CTL, 8'h81);
         wr(OFS_LONG_CTL, 8'h80);
         cycles(3);
         chk("short_start", 8'(v), {7'h0, TIMER_OUT_PIN_A});
         chk("long_start", 8'(v), {7'h0, COMBINED_OUT_PIN});
         wr(OFS_SHORT_CTL, 8'h01);
         wr(OFS_LONG_CTL, 8'h00);
      end
      for (lg = 0; lg < 4; lg++)
         for (f = 0; f < 2; f++)
            for (v = 0; v < 2; v++) begin
               wr(OFS_COMMON_CTL, 8'(8'h40 | (lg << 4) | ((2 + f) << 2) | (v << 1)));
               cycles(3);
               chk("combined", {7'h0, comb(lg, ~v[0], f[0])},
                   {7'h0, COMBINED_OUT_PIN});
            end
      wr(OFS_SHORT_RELOAD, 8'h02);
      wr(OFS_LONG_HI, 8'h00);
      wr(OFS_LONG_LO, 8'h04);
      wr(OFS_COMMON_CTL, 8'h44);
      wr(OFS_SHORT_CTL, 8'h81);
      period(n);
      period(rl);
      period(n);
      // Ping-pong alternates the timers, so one full cycle spans both reloads.
      chk("pingpong", 8'h08, 8'(rl + n));
      wr(OFS_COMMON_CTL, 8'h00);
      wr(OFS_SHORT_CTL, 8'h01);
      wr(OFS_LONG_CTL, 8'h00);
      rdchk("long_ctl", OFS_LONG_CTL, 8'h20);
      rdchk("irq_stat", OFS_IRQ_STAT, 8'h03);
      cycles(2);
      follow("combined_port", 1'b1);
      wr(OFS_COMMON_CTL, 8'hc0);
      wr(OFS_IRQ_MASK, 8'h0c);
      rdchk("irq_mask", OFS_IRQ_MASK, 8'h0c);
      follow("demod_port", 1'b1);
      for (sel = 0; sel < 2; sel++)
         for (e = 0; e < 3; e++)
            for (g = 0; g < 4; g++) begin
               thr = (g == 1) ? 4 : (g == 2) ? 8 : 0;
               cfg = 8'(8'h80 | (sel << 6) | (e << 4) | (g << 2));
               wr(OFS_COMMON_CTL, cfg | 8'h03);
               wr(OFS_IRQ_STAT, 8'h0f);
               c0 = caps;
               for (n = (thr > 0) ? 0 : 1; n < 2; n++) begin
                  if (sel == 1)
                     DEMOD_PIN_B <= 1'b1;
                  else
                     DEMOD_PIN_A <= 1'b1;
                  repeat ((n == 0) ? thr - 1 : thr + 1) @(posedge CORE_CLK);
                  DEMOD_PIN_A <= 1'b0;
                  DEMOD_PIN_B <= 1'b0;
                  repeat (16) @(posedge CORE_CLK);
                  if (n == 0)
                     rdchk("glitch", OFS_COMMON_CTL, cfg);
               end
               fl = 8'(((e != 1) ? 2 : 0) | ((e != 0) ? 1 : 0));
               rdchk("edge_flags", OFS_COMMON_CTL, cfg | fl);
               rdchk("irq_stat", OFS_IRQ_STAT,
                     8'(((e != 0) ? 8 : 0) | ((e != 1) ? 4 : 0)));
               chk("irq", 8'h01, {7'h0, IRQ});
               chk("capture", 8'(sel * ((e == 2) ? 2 : 1)), 8'(caps - c0));
            end
      wr(OFS_COMMON_CTL, 8'h83);
      rdchk("flags_clear", OFS_COMMON_CTL, 8'h80);
      summarize();
   end
endmodule
